// *** hw/emsp_defines.vh ***
// Constants for the external memory strobe and select pin block
`ifndef EMSP_DEFINES_VH
`define EMSP_DEFINES_VH
`define EMSP_ADDR_W 17
`define EMSP_DATA_W 16
`define EMSP_PD_ZERO 0
`define EMSP_PD_EIGHT 8
`define EMSP_PD_NINE 9
`define EMSP_PORT_D_W 16
`define EMSP_GPS_CS2_BIT 4
`define EMSP_DRV_RESET 1'b0
`define EMSP_PER_RESET 16'h0000
`define EMSP_PUR_RESET 16'hffff
`define EMSP_SETUP_NS 40
`define EMSP_STROBE_NS 80
`define EMSP_HOLD_NS 40
`define EMSP_CLK_MHZ 25
`define EMSP_CYC_MIN(ns) ((((ns) * `EMSP_CLK_MHZ) + 999) / 1000)
`define EMSP_ST_IDLE 2'h0
`define EMSP_ST_SETUP 2'h1
`define EMSP_ST_STROBE 2'h2
`define EMSP_ST_HOLD 2'h3
`endif

// *** hw/emsp_sync2.v ***
// Two flip-flop synchroniser for a bank of pin inputs
module emsp_sync2 #(
   parameter W = 3
) (
   input wire i_clk_sys,
   input wire i_resetn,
   input wire [W-1:0] i_async,
   output reg [W-1:0] o_sync
);
   reg [W-1:0] stage_one;

   always @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         stage_one <= {W{1'b0}};
         o_sync <= {W{1'b0}};
      end else begin
         stage_one <= i_async;
         o_sync <= stage_one;
      end
   end
endmodule // emsp_sync2

// *** hw/emsp_region_match.v ***
// Region decoder for the programmable chip select two
module emsp_region_match #(
   parameter AW = 17
) (
   input wire [AW-1:0] i_addr,
   input wire i_prog_space,
   input wire i_enable,
   input wire i_match_prog,
   input wire i_match_data,
   input wire [AW-1:0] i_base,
   input wire [AW-1:0] i_mask,
   output wire o_hit
);
   // Address bits under the mask must equal the base
   wire addr_ok;
   wire space_ok;

   assign addr_ok = ((i_addr ^ i_base) & i_mask) == {AW{1'b0}};
   assign space_ok = i_prog_space ? i_match_prog : i_match_data;
   assign o_hit = i_enable & addr_ok & space_ok;
endmodule // emsp_region_match

// *** hw/emsp_pins.v ***
// External memory write strobe, select pins and port D pin sharing
`include "emsp_defines.vh"

module emsp_pins #(
   parameter AW = `EMSP_ADDR_W,
   parameter DW = `EMSP_DATA_W,
   parameter SETUP_NS = `EMSP_SETUP_NS,
   parameter STROBE_NS = `EMSP_STROBE_NS,
   parameter HOLD_NS = `EMSP_HOLD_NS
) (
   input wire i_clk_sys,
   input wire i_resetn,
   input wire i_req_valid,
   input wire i_req_write,
   input wire i_req_prog_space,
   input wire [AW-1:0] i_req_addr,
   input wire [DW-1:0] i_req_wdata,
   output wire o_req_ready,
   output reg o_busy,
   input wire i_read_strobe_n,
   input wire i_bus_drive_keep,
   input wire i_cs0_enable,
   input wire i_cs1_enable,
   input wire i_cs2_enable,
   input wire i_cs2_match_prog,
   input wire i_cs2_match_data,
   input wire [AW-1:0] i_cs2_base,
   input wire [AW-1:0] i_cs2_mask,
   input wire [`EMSP_PORT_D_W-1:0] i_port_d_peripheral_enable,
   input wire [`EMSP_PORT_D_W-1:0] i_port_d_pullup_enable,
   input wire [`EMSP_PORT_D_W-1:0] i_port_d_dir_out,
   input wire [`EMSP_PORT_D_W-1:0] i_port_d_data_out,
   input wire [7:0] i_peripheral_select_reg,
   input wire i_pullup_disable_ctrl,
   input wire i_second_can_transmit,
   input wire [2:0] i_port_d_pins,
   output wire [2:0] o_port_d_in,
   output reg [AW-1:0] o_address_lines,
   output reg [DW-1:0] o_data_lines,
   output reg o_data_lines_oe,
   output reg o_write_strobe_n,
   output wire o_write_strobe_oe,
   output wire o_write_strobe_pullup,
   output reg o_program_space_select_n,
   output wire o_program_space_select_oe,
   output reg o_data_space_select_n,
   output wire o_data_space_select_oe,
   output wire o_chip_select_two_out,
   output wire o_chip_select_two_pin_oe,
   output wire [2:0] o_port_d_pullup_on,
   output reg o_write_done
);
   // Phase lengths in cycles, at least one, cut to the counter width
   localparam integer SETUP_RAW = (`EMSP_CYC_MIN(SETUP_NS) < 1) ? 1 :
      `EMSP_CYC_MIN(SETUP_NS);
   localparam integer STROBE_RAW = (`EMSP_CYC_MIN(STROBE_NS) < 1) ? 1 :
      `EMSP_CYC_MIN(STROBE_NS);
   localparam integer HOLD_RAW = (`EMSP_CYC_MIN(HOLD_NS) < 1) ? 1 :
      `EMSP_CYC_MIN(HOLD_NS);
   localparam [7:0] SETUP_CYC = SETUP_RAW[7:0];
   localparam [7:0] STROBE_CYC = STROBE_RAW[7:0];
   localparam [7:0] HOLD_CYC = HOLD_RAW[7:0];

   reg [1:0] state;
   reg [1:0] next_state;
   reg [7:0] count;
   reg [7:0] next_count;
   reg cur_prog;
   reg chip_select_two;
   reg chip_select_zero;
   reg chip_select_one;
   reg [AW-1:0] addr_q;
   reg [DW-1:0] wdata_q;
   wire cs2_hit;
   wire rd_low_sync;
   wire [2:0] pins_sync;
   wire bus_active;
   wire cs2_is_periph;
   wire cs2_is_chipsel;
   wire [2:0] pd_idx_per;
   wire [2:0] pd_dir;
   wire [2:0] pd_out;
   wire [2:0] pd_pur;

   // Read strobe and shared pins come from outside the clock domain
   emsp_sync2 #(.W(4)) u_sync (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_async({~i_read_strobe_n, i_port_d_pins}),
      .o_sync({rd_low_sync, pins_sync})
   );
   assign o_port_d_in = pins_sync;

   emsp_region_match #(.AW(AW)) u_cs2 (
      .i_addr(i_req_addr),
      .i_prog_space(i_req_prog_space),
      .i_enable(i_cs2_enable),
      .i_match_prog(i_cs2_match_prog),
      .i_match_data(i_cs2_match_data),
      .i_base(i_cs2_base),
      .i_mask(i_cs2_mask),
      .o_hit(cs2_hit)
   );

   // Write requests only; wait while the read strobe is low
   assign o_req_ready = (state == `EMSP_ST_IDLE) && !rd_low_sync;

   always @* begin
      next_state = state;
      next_count = count;
      case (state)
         `EMSP_ST_IDLE: begin
            if (i_req_valid && i_req_write && o_req_ready) begin
               next_state = `EMSP_ST_SETUP;
               next_count = SETUP_CYC;
            end
         end
         `EMSP_ST_SETUP: begin
            if (count == 8'h01) begin
               next_state = `EMSP_ST_STROBE;
               next_count = STROBE_CYC;
            end else begin
               next_count = count - 8'h01;
            end
         end
         `EMSP_ST_STROBE: begin
            if (count == 8'h01) begin
               next_state = `EMSP_ST_HOLD;
               next_count = HOLD_CYC;
            end else begin
               next_count = count - 8'h01;
            end
         end
         `EMSP_ST_HOLD: begin
            if (count == 8'h01) begin
               next_state = `EMSP_ST_IDLE;
               next_count = 8'h00;
            end else begin
               next_count = count - 8'h01;
            end
         end
         default: begin
            next_state = `EMSP_ST_IDLE;
            next_count = 8'h00;
         end
      endcase
   end

   always @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         state <= `EMSP_ST_IDLE;
         count <= 8'h00;
         cur_prog <= 1'b0;
         addr_q <= {AW{1'b0}};
         wdata_q <= {DW{1'b0}};
         chip_select_zero <= 1'b0;
         chip_select_one <= 1'b0;
         chip_select_two <= 1'b0;
         o_write_strobe_n <= 1'b1;
         o_program_space_select_n <= 1'b1;
         o_data_space_select_n <= 1'b1;
         o_address_lines <= {AW{1'b0}};
         o_data_lines <= {DW{1'b0}};
         o_data_lines_oe <= 1'b0;
         o_busy <= 1'b0;
         o_write_done <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         o_write_done <= 1'b0;
         // Selects latched once per write, stable through the strobe
         if (state == `EMSP_ST_IDLE && next_state == `EMSP_ST_SETUP) begin
            cur_prog <= i_req_prog_space;
            addr_q <= i_req_addr;
            wdata_q <= i_req_wdata;
            chip_select_zero <= i_req_prog_space & i_cs0_enable;
            chip_select_one <= ~i_req_prog_space & i_cs1_enable;
            chip_select_two <= cs2_hit;
            o_address_lines <= i_req_addr;
            o_program_space_select_n <=
               ~(i_req_prog_space & i_cs0_enable);
            o_data_space_select_n <=
               ~(~i_req_prog_space & i_cs1_enable);
            o_busy <= 1'b1;
         end
         // Strobe low only in the strobe phase of a write
         o_write_strobe_n <= !(next_state == `EMSP_ST_STROBE);
         // Data driven from setup through hold so it is valid at the rise
         o_data_lines_oe <= (next_state != `EMSP_ST_IDLE);
         o_data_lines <= (next_state == `EMSP_ST_IDLE) ? o_data_lines :
            wdata_q;
         if (state == `EMSP_ST_HOLD && next_state == `EMSP_ST_IDLE) begin
            o_program_space_select_n <= 1'b1;
            o_data_space_select_n <= 1'b1;
            chip_select_zero <= 1'b0;
            chip_select_one <= 1'b0;
            chip_select_two <= 1'b0;
            o_busy <= 1'b0;
            o_write_done <= 1'b1;
         end
      end
   end

   assign bus_active = (state != `EMSP_ST_IDLE);

   // Idle control outputs float unless drive-keep is set
   assign o_write_strobe_oe = bus_active | i_bus_drive_keep;
   assign o_write_strobe_pullup = ~i_pullup_disable_ctrl;

   // Port D line mapping: index 0 is line 8, 1 is line 9, 2 is line 0
   assign pd_idx_per = {i_port_d_peripheral_enable[`EMSP_PD_ZERO],
      i_port_d_peripheral_enable[`EMSP_PD_NINE],
      i_port_d_peripheral_enable[`EMSP_PD_EIGHT]};
   assign pd_dir = {i_port_d_dir_out[`EMSP_PD_ZERO],
      i_port_d_dir_out[`EMSP_PD_NINE],
      i_port_d_dir_out[`EMSP_PD_EIGHT]};
   assign pd_out = {i_port_d_data_out[`EMSP_PD_ZERO],
      i_port_d_data_out[`EMSP_PD_NINE],
      i_port_d_data_out[`EMSP_PD_EIGHT]};
   assign pd_pur = {i_port_d_pullup_enable[`EMSP_PD_ZERO],
      i_port_d_pullup_enable[`EMSP_PD_NINE],
      i_port_d_pullup_enable[`EMSP_PD_EIGHT]};

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_pullup
         assign o_port_d_pullup_on[g] = pd_pur[g];
      end
   endgenerate

   // Lines 8 and 9 take the GPIO direction but still drive the select levels when not given to the memory interface
   assign o_program_space_select_oe = pd_idx_per[0] ?
      (bus_active | i_bus_drive_keep) : pd_dir[0];
   assign o_data_space_select_oe = pd_idx_per[1] ?
      (bus_active | i_bus_drive_keep) : pd_dir[1];

   // Line 0: GPIO, chip select two, or open-drain second CAN transmit
   assign cs2_is_periph = pd_idx_per[2];
   assign cs2_is_chipsel = cs2_is_periph &
      i_peripheral_select_reg[`EMSP_GPS_CS2_BIT];
   assign o_chip_select_two_out = !cs2_is_periph ? pd_out[2] :
      cs2_is_chipsel ? ~chip_select_two : 1'b0;
   assign o_chip_select_two_pin_oe = !cs2_is_periph ? pd_dir[2] :
      cs2_is_chipsel ? (bus_active | i_bus_drive_keep) :
      ~i_second_can_transmit;
endmodule // emsp_pins

// *** tb/emsp_monitor.sv ***
// Checker of strobe timing and pin controls of the pin block
module emsp_monitor (
   input logic i_clk_sys,
   input logic i_resetn,
   input logic i_req_valid,
   input logic i_req_write,
   input logic i_read_strobe_n,
   input logic i_bus_drive_keep,
   input logic i_pullup_disable_ctrl,
   input logic [15:0] i_port_d_pullup_enable,
   input logic o_req_ready,
   input logic o_busy,
   input logic o_data_lines_oe,
   input logic o_write_strobe_n,
   input logic o_write_strobe_oe,
   input logic o_write_strobe_pullup,
   input logic o_program_space_select_n,
   input logic o_data_space_select_n,
   input logic [2:0] o_port_d_pullup_on,
   input logic o_write_done
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_resetn);
   sequence s_take;
      i_req_valid && i_req_write && o_req_ready;
   endsequence
   sequence s_cycle;
      o_busy && o_write_strobe_n ##1 !o_write_strobe_n [*2]
         ##1 o_write_strobe_n ##1 o_write_done;
   endsequence
   a_write_walk: assert property (s_take |=> s_cycle)
      else $error("Write cycle out of step");
   a_strobe_data: assert property (!o_write_strobe_n |-> o_data_lines_oe)
      else $error("Data not driven under strobe");
   a_sel_stable: assert property (!o_write_strobe_n |->
      $stable(o_program_space_select_n) && $stable(o_data_space_select_n))
      else $error("Select moved under strobe");
   a_one_select: assert property (!o_write_strobe_n |->
      o_program_space_select_n != o_data_space_select_n)
      else $error("Space selects wrong under strobe");
   a_idle_quiet: assert property (!o_busy |-> o_write_strobe_n &&
      o_program_space_select_n && o_data_space_select_n)
      else $error("Strobe or select low while idle");
   a_idle_drive: assert property (!o_busy |->
      o_write_strobe_oe == i_bus_drive_keep)
      else $error("Idle strobe enable wrong");
   a_busy_ready: assert property (o_busy |-> !o_req_ready)
      else $error("Ready while busy");
   a_read_block: assert property (!i_read_strobe_n [*3] |-> !o_req_ready)
      else $error("Ready while read strobe low");
   a_strobe_pull: assert property (
      o_write_strobe_pullup == !i_pullup_disable_ctrl)
      else $error("Strobe pull-up wrong");
   a_port_pull: assert property (o_port_d_pullup_on ==
      {i_port_d_pullup_enable[0], i_port_d_pullup_enable[9:8]})
      else $error("Port pull-ups wrong");
endmodule // emsp_monitor

bind emsp_pins emsp_monitor u_mon (.*);

// *** tb/emsp_sram_model.sv ***
// Static RAM model that latches a write at the strobe rising edge
module emsp_sram_model (
   input logic i_we_n,
   input logic i_oe,
   input logic i_ps_n,
   input logic i_ds_n,
   input logic i_cs2,
   input logic [16:0] i_a,
   input logic [15:0] i_d,
   output logic [16:0] o_a,
   output logic [15:0] o_d,
   output logic o_prog,
   output logic o_cs2
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge i_we_n) begin
      if (i_oe && (!i_ps_n || !i_ds_n)) begin
         o_a <= i_a;
         o_d <= i_d;
         o_prog <= !i_ps_n;
         o_cs2 <= i_cs2;
      end
   end
endmodule // emsp_sram_model

// *** tb/tb_emsp_pins.sv ***
// Self-checking bench of the strobe and select pin block
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
   $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_emsp_pins;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys, i_resetn, i_req_valid, i_req_write, i_req_prog_space;
   logic i_read_strobe_n, i_bus_drive_keep, i_cs0_enable, i_cs1_enable;
   logic i_cs2_enable, i_cs2_match_prog, i_cs2_match_data;
   logic i_pullup_disable_ctrl, i_second_can_transmit, o_write_done;
   logic [16:0] i_req_addr, i_cs2_base, i_cs2_mask, o_address_lines, m_a;
   logic [15:0] i_req_wdata, o_data_lines, m_d, i_port_d_data_out;
   logic [15:0] i_port_d_peripheral_enable, i_port_d_pullup_enable;
   logic [15:0] i_port_d_dir_out;
   logic [7:0] i_peripheral_select_reg;
   logic [2:0] i_port_d_pins, o_port_d_in, o_port_d_pullup_on;
   logic o_req_ready, o_busy, o_data_lines_oe, o_write_strobe_n, m_p, m_c;
   logic o_write_strobe_oe, o_write_strobe_pullup, o_program_space_select_n;
   logic o_program_space_select_oe, o_data_space_select_n;
   logic o_data_space_select_oe, o_chip_select_two_out;
   logic o_chip_select_two_pin_oe;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   emsp_pins dut (.*);
   emsp_sram_model u_mem (.i_we_n(o_write_strobe_n), .i_oe(o_data_lines_oe),
      .i_ps_n(o_program_space_select_n), .i_ds_n(o_data_space_select_n),
      .i_cs2(o_chip_select_two_out), .i_a(o_address_lines),
      .i_d(o_data_lines), .o_a(m_a), .o_d(m_d), .o_prog(m_p), .o_cs2(m_c));
   initial begin
      i_clk_sys = 0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         test_done;
      end
   end
   task automatic test_done;
      $display("Checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic p, input logic [16:0] a,
      input logic [15:0] d);
      int k;
      {i_req_prog_space, i_req_addr, i_req_wdata} = {p, a, d};
      {i_req_valid, i_req_write, k} = {2'b11, 32'd0};
      while (o_req_ready !== 1'b1 && k++ < 30) @(negedge i_clk_sys);
      @(negedge i_clk_sys);
      {i_req_valid, k} = 0;
      while (o_write_done !== 1'b1 && k++ < 9) @(negedge i_clk_sys);
      `CHK({o_write_done, m_p, m_a, m_d}, {1'b1, p, a, d})
      @(negedge i_clk_sys);
   endtask
   task automatic t_reset;
      `CHK({o_write_strobe_n, o_busy, o_data_lines_oe}, 3'b100)
      `CHK(o_program_space_select_n & o_data_space_select_n, 1'b1)
      `CHK(o_chip_select_two_pin_oe, 1'b0)
      $display("t_reset done");
   endtask
   task automatic t_write;
      wr(1, 17'h1ffff, 16'ha5c3);
      wr(0, 17'h00000, 16'h5a3c);
      $display("t_write done");
   endtask
   task automatic t_refuse;
      {i_req_valid, i_req_write} = 2'b10;
      repeat (4) @(negedge i_clk_sys);
      `CHK(o_busy, 1'b0)
      i_read_strobe_n = 0;
      repeat (3) @(negedge i_clk_sys);
      i_req_write = 1;
      repeat (5) @(negedge i_clk_sys);
      `CHK({o_busy, o_req_ready}, 2'b00)
      i_read_strobe_n = 1;
      wr(1, 17'h00abc, 16'h0f0f);
      $display("t_refuse done");
   endtask
   task automatic t_idle;
      @(negedge i_clk_sys);
      `CHK({o_write_strobe_oe, o_program_space_select_oe}, 2'b00)
      i_bus_drive_keep = 1;
      @(negedge i_clk_sys);
      `CHK({o_write_strobe_oe, o_data_space_select_oe}, 2'b11)
      $display("t_idle done");
   endtask
   task automatic t_cs2;
      i_port_d_peripheral_enable = 16'h0301;
      i_peripheral_select_reg = 8'h10;
      {i_cs2_base, i_cs2_mask} = {17'h01000, 17'h1f000};
      {i_cs2_enable, i_cs2_match_prog, i_cs2_match_data} = 3'b110;
      wr(1, 17'h01234, 16'h1111);
      `CHK(m_c, 1'b0)
      wr(1, 17'h05234, 16'h2222);
      `CHK(m_c, 1'b1)
      wr(0, 17'h01234, 16'h3333);
      `CHK(m_c, 1'b1)
      {i_peripheral_select_reg, i_second_can_transmit} = 0;
      @(negedge i_clk_sys);
      `CHK({o_chip_select_two_pin_oe, o_chip_select_two_out}, 2'b10)
      i_second_can_transmit = 1;
      @(negedge i_clk_sys);
      `CHK(o_chip_select_two_pin_oe, 1'b0)
      $display("t_cs2 done");
   endtask
   task automatic t_pins;
      {i_port_d_peripheral_enable, i_port_d_dir_out} = {16'h0, 16'h0101};
      {i_port_d_pins, i_pullup_disable_ctrl} = {3'b101, 1'b1};
      i_port_d_pullup_enable = 16'h0201;
      i_port_d_data_out = 16'h0001;
      repeat (3) @(negedge i_clk_sys);
      `CHK({o_chip_select_two_pin_oe, o_chip_select_two_out}, 2'b11)
      `CHK(o_port_d_in, 3'b101)
      `CHK({o_program_space_select_oe, o_data_space_select_oe}, 2'b10)
      `CHK({o_write_strobe_pullup, o_port_d_pullup_on}, 4'b0110)
      $display("t_pins done");
   endtask
   initial begin
      {i_resetn, i_req_valid, i_req_write, i_req_prog_space} = 0;
      {i_req_addr, i_req_wdata, i_cs2_base, i_cs2_mask} = 0;
      {i_read_strobe_n, i_bus_drive_keep, i_cs0_enable, i_cs1_enable} = 4'hb;
      {i_cs2_enable, i_cs2_match_prog, i_cs2_match_data} = 0;
      {i_pullup_disable_ctrl, i_second_can_transmit, i_port_d_pins} = 0;
      {i_port_d_peripheral_enable, i_port_d_dir_out} = {16'h0300, 16'h0};
      {i_port_d_pullup_enable, i_port_d_data_out} = {16'hffff, 16'h0};
      i_peripheral_select_reg = 0;
      repeat (8) @(negedge i_clk_sys);
      t_reset;
      i_resetn = 1;
      repeat (3) @(negedge i_clk_sys);
      t_idle;
      t_write;
      t_refuse;
      t_cs2;
      t_pins;
      test_done;
   end
endmodule // tb_emsp_pins
